// >>> design/nlc_map.vh
// constants for the nested loop counter
`ifndef NLC_MAP_VH
`define NLC_MAP_VH

// number of loop levels (length of the limit vector)
`define NLC_LEVELS 3
// width of each level's counter and limit
`define NLC_CW 8
// value every counter takes at start and after reset
`define NLC_CNT_RESET 8'h00
// limit value held after reset
`define NLC_LIM_RESET 8'h00

`endif

// >>> design/nlc_top.v
// nested loop index generator with per-level first and last flags
//
// Overview of operation
// - on start, the limit vector is captured as the new loop bounds
// - one counter per limit vector element; vector length sets nesting depth
// - each counter runs from zero to its limit minus one, then wraps
// - every enabled cycle while running, with no start in that cycle, the current counter values appear on the index output
// - valid is high for the one cycle in which a new vector lands on the index output; index then holds it
// - first flag marks counter at zero; last flag marks counter at limit minus one
// - last element is innermost; outer levels step when all inner levels wrap
// - counters advance only in enabled cycles; valid signals forward flow
`timescale 1ns/1ps
`include "nlc_map.vh"

module nlc_top (
  input wire mclk, // 40 mhz clock
  input wire reset, // synchronous, active high
  input wire start, // one-cycle pulse, loads limits
  input wire [`NLC_LEVELS*`NLC_CW-1:0] limits, // element 0 in low bits, outermost
  input wire enable, // iteration pacing from upstream
  output reg valid, // index vector valid this cycle
  output reg [`NLC_LEVELS*`NLC_CW-1:0] index, // element 0 outermost
  output reg [`NLC_LEVELS-1:0] first, // per-level counter at zero
  output reg [`NLC_LEVELS-1:0] last, // per-level counter at limit minus one
  output reg busy // loop sequence in progress
);

  localparam N = `NLC_LEVELS;
  localparam W = `NLC_CW;

  // one-hot sequencing states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // counter-width constants keep every add and compare at W bits
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam [W-1:0] ZERO = {W{1'b0}};

  // sequencing state and its next value
  reg [1:0] state;
  reg [1:0] next_state;

  // captured bounds; held so a limits change mid-run cannot disturb the nest
  reg [N*W-1:0] lim;
  reg [N*W-1:0] next_lim;

  // live counters, element 0 outermost
  reg [N*W-1:0] cnt;
  reg [N*W-1:0] next_cnt;

  // per-level decode of the live counters
  wire [N-1:0] at_last;
  wire [N-1:0] at_zero;
  wire [N-1:0] wrap_ok;
  wire [N-1:0] step;
  wire [N*W-1:0] advanced;

  // an incoming limit vector with an empty level
  wire [N-1:0] lim_zero;
  wire bad_limits;

  // qualified strobes
  wire running;
  wire take_step;
  wire final_step;

  genvar g;

  // one counter slice per limit element; the vector length fixes the depth
  generate
    for (g = 0; g < N; g = g + 1) begin : lvl
      wire [W-1:0] c_now;
      wire [W-1:0] l_now;
      wire [W-1:0] c_inc;

      assign c_now = cnt[g*W +: W];
      assign l_now = lim[g*W +: W];

      // limit minus one wraps at W bits, harmless since a zero limit never runs
      assign at_last[g] = (c_now == l_now - ONE);
      assign at_zero[g] = (c_now == ZERO);

      // roll over to zero after the last value
      assign c_inc = at_last[g] ? ZERO : c_now + ONE;

      // a level only moves when its step strobe is up
      assign advanced[g*W +: W] = step[g] ? c_inc : c_now;

      // zero check on the incoming vector, not the captured one
      assign lim_zero[g] = (limits[g*W +: W] == ZERO);
    end
  endgenerate

  // innermost level closes the carry chain
  assign wrap_ok[N-1] = at_last[N-1];
  // the innermost level steps on every taken enable
  assign step[N-1] = 1'b1;

  // a level wraps when it and every inner level sit at their last value
  generate
    for (g = 0; g < N-1; g = g + 1) begin : chain
      assign wrap_ok[g] = at_last[g] & wrap_ok[g+1];
      // outer levels step only when all inner levels wrap together
      assign step[g] = wrap_ok[g+1];
    end
  endgenerate

  // an empty level means an empty nest, so the block stays idle
  assign bad_limits = |lim_zero;

  // strobes: start wins over enable in the same cycle
  assign running = (state == ST_RUN);
  assign take_step = running & enable & ~start;
  assign final_step = take_step & wrap_ok[0];

  // next state, bounds and counters
  always @* begin
    next_state = state;
    next_lim = lim;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_lim = limits;
          next_cnt = {N{`NLC_CNT_RESET}};
          if (!bad_limits) begin
            next_state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (start) begin
          // a fresh start restarts the sequence with new bounds
          next_lim = limits;
          next_cnt = {N{`NLC_CNT_RESET}};
          if (bad_limits) begin
            next_state = ST_IDLE;
          end
        end else if (enable) begin
          next_cnt = advanced;
          if (wrap_ok[0]) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register; idle out of reset
  always @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bound register
  always @(posedge mclk) begin
    if (reset) begin
      lim <= {N{`NLC_LIM_RESET}};
    end else begin
      lim <= next_lim;
    end
  end

  // counter register
  always @(posedge mclk) begin
    if (reset) begin
      cnt <= {N{`NLC_CNT_RESET}};
    end else begin
      cnt <= next_cnt;
    end
  end

  // valid: one pulse per taken enable
  always @(posedge mclk) begin
    if (reset) begin
      valid <= 1'b0;
    end else begin
      valid <= take_step;
    end
  end

  // busy lags the state by one edge and drops with the final vector
  always @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0;
    end else begin
      busy <= running & ~final_step;
    end
  end

  // index holds between vectors so a slow consumer can still read it
  always @(posedge mclk) begin
    if (reset) begin
      index <= {N{`NLC_CNT_RESET}};
    end else if (take_step) begin
      index <= cnt;
    end
  end

  // first flags, updated only with a vector
  always @(posedge mclk) begin
    if (reset) begin
      first <= {N{1'b0}};
    end else if (take_step) begin
      first <= at_zero;
    end
  end

  // last flags, updated only with a vector
  always @(posedge mclk) begin
    if (reset) begin
      last <= {N{1'b0}};
    end else if (take_step) begin
      last <= at_last;
    end
  end

endmodule

// >>> tb/nlc_top_assertions.sv
// port checks for the nested loop counter
`timescale 1ns/1ps
module nlc_chk(input wire mclk, reset, start, enable, valid, busy,
  input wire [23:0] limits, index, input wire [2:0] first, last);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // two emitted vectors in a row without an inner wrap
  sequence s_step; valid && !last[2] ##1 valid; endsequence
  property p_vld; valid |-> $past(enable) && !$past(start); endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_rst; $past(reset) |-> !valid && !busy; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_flg; valid |-> first == {index[23:16]==0, index[15:8]==0, index[7:0]==0}; endproperty
  a_flg: assert property (p_flg) else $error("first");
  property p_inc; s_step |-> index[23:16] == $past(index[23:16]) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("inner");
  property p_wrap; valid && last[2] && !last[1] ##1 valid |->
    index[23:8] == {8'h00, $past(index[15:8]) + 8'h01}; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_hold; !valid && !$past(reset) |-> $stable(index); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_end; valid && &last |=> !valid; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_go; start |=> !valid; endproperty
  a_go: assert property (p_go) else $error("go");
endmodule
bind nlc_top nlc_chk u_chk(.mclk, .reset, .start, .enable, .valid, .busy, .limits, .index,
  .first, .last);

// >>> tb/nlc_ctl.sv
// upstream controller model: start, limits and enable pacing
`timescale 1ns/1ps
module nlc_ctl(input wire mclk, output reg start = 0, output reg [23:0] limits = 0,
  output reg enable = 0);
  reg on = 0, paced = 0;
  // paced mode drops enable every other cycle to stall the loop
  always @(negedge mclk) enable <= on & (!paced | !enable);
  // limits are inverted once taken, so stale bounds cannot pass
  task go(input [23:0] l); begin
    @(negedge mclk) {start, limits} <= {1'b1, l};
    @(negedge mclk) {start, limits} <= {1'b0, ~l};
  end endtask
endmodule

// >>> tb/nlc_top_tb.sv
// testbench for the nested loop counter
`timescale 1ns/1ps
module nlc_top_tb;
  reg mclk = 0, reset = 1;
  wire start, enable, valid, busy;
  wire [23:0] limits, index;
  wire [2:0] first, last;
  integer failures = 0, tests_run = 0;
  nlc_ctl ctl(.mclk, .start, .limits, .enable);
  nlc_top dut(.mclk, .reset, .start, .limits, .enable, .valid, .index, .first, .last, .busy);
  initial forever #12.5 mclk = ~mclk;
  task chk(input [8*6:1] n, input [25:0] s, e); begin
    tests_run++;
    if (s !== e) begin failures++; $display("wrong value %0s exp %h seen %h", n, e, s); end
  end endtask
  task tally_and_finish; begin
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  end endtask
  // walk the loops in c order; bounded wait for each vector
  task run(input [23:0] l, input p); integer a, b, c, w; begin
    ctl.paced = p; ctl.go(l); ctl.on = 1;
    for (a = 0; a < l[7:0]; a++) for (b = 0; b < l[15:8]; b++) for (c = 0; c < l[23:16]; c++) begin
      w = 0; @(negedge mclk);
      while (!valid && w < 9) begin w++; @(negedge mclk); end
      chk("vector", {valid, index}, {1'b1, c[7:0], b[7:0], a[7:0]});
      chk("flags", {first, last}, {c==0, b==0, a==0, c==l[23:16]-1, b==l[15:8]-1, a==l[7:0]-1});
      chk("busy", busy, !(c==l[23:16]-1 && b==l[15:8]-1 && a==l[7:0]-1));
    end
    repeat (4) @(negedge mclk) chk("idle", {valid, busy}, 0);
    ctl.on = 0;
  end endtask
  task sc_walk; run(24'h020102, 0); endtask
  task sc_paced; run(24'h040203, 1); endtask
  task sc_empty; run(24'h030003, 0); endtask
  // restart in mid-run with new bounds
  task sc_restart; begin ctl.go(24'h050505); ctl.on = 1; repeat (6) @(negedge mclk); run(24'h010302, 1); end endtask
  initial begin
    repeat (2) @(negedge mclk); reset = 0;
    chk("reset", {valid, busy, index}, 0);
    sc_walk; sc_paced; sc_empty; sc_restart;
    tally_and_finish;
  end
  initial begin #100000; failures++; tally_and_finish; end
endmodule
